// ---- shared/plc_map.vh ----
`ifndef PLC_MAP_VH
`define PLC_MAP_VH
`define PLC_IDX_LED_OVR 8'h18
`define PLC_IDX_PHY_CTL 8'h19
`define PLC_ADDR_LED_OVR 12'h060
`define PLC_ADDR_PHY_CTL 12'h064
`define PLC_ADDR_IRQ_STAT 12'h080
`define PLC_ADDR_IRQ_MASK 12'h084
`define PLC_ADDR_LED_IN 12'h088
`define PLC_LED_OVR_MASK 16'h003F
`define PLC_BIT_SPD_EN 5
`define PLC_BIT_LNK_EN 4
`define PLC_BIT_ACT_EN 3
`define PLC_BIT_SPD_VAL 2
`define PLC_BIT_LNK_VAL 1
`define PLC_BIT_ACT_VAL 0
`define PLC_BIT_XOVER_EN 15
`define PLC_BIT_FORCE_X 14
`define PLC_BIT_PAUSE_RX 13
`define PLC_BIT_PAUSE_TX 12
`define PLC_BIT_INJ_ERR 11
`define PLC_BIT_LONG_SEQ 10
`define PLC_BIT_PASS 9
`define PLC_BIT_RUN 8
`define PLC_BIT_BYPASS 7
`define PLC_PHY_CTL_WMASK 16'hC5FF
`define PLC_IRQ_BITS 3
`define PLC_IRQ_FAIL 0
`define PLC_IRQ_PAUSE 1
`define PLC_IRQ_INJ 2
`endif

// ---- verilog/plc_pause_resolve.v ----
`timescale 1ns/100ps
// pause resolution from advertised [11:10] pairs: asym, sym
module plc_pause_resolve (
    input wire [1:0] local_pause,
    input wire [1:0] partner_pause,
    input wire full_duplex,
    output reg pause_rx,
    output reg pause_tx
);
    always @* begin
        pause_rx = 1'b0;
        pause_tx = 1'b0;
        if (full_duplex) begin
            if (local_pause[0] && partner_pause[0]) begin
                pause_rx = 1'b1;
                pause_tx = 1'b1;
            end else if (local_pause == 2'h3 && partner_pause == 2'h2) begin
                pause_rx = 1'b1;
            end else if (local_pause == 2'h2 && partner_pause == 2'h3) begin
                pause_tx = 1'b1;
            end
        end
    end
endmodule // plc_pause_resolve

// ---- verilog/plc_led_mux.v ----
`timescale 1ns/100ps
// one indicator: stretched or raw, then optional override
module plc_led_mux (
    input wire raw_ind,
    input wire stretched_ind,
    input wire bypass,
    input wire override_en,
    input wire forced_value,
    output wire led_out
);
    wire normal_w;
    assign normal_w = bypass ? raw_ind : stretched_ind;
    assign led_out = override_en ? forced_value : normal_w;
endmodule // plc_led_mux

// ---- verilog/plc_regs.v ----
// Function
// - upper ten override bits ignored, read zero
// - override enable makes LED follow forced value
// - bits 2:0 hold forced levels, reset zero
// - reads return stored settings, not pins
// - bit 15 enables auto crossover, strap reset
// - bit 14 forces crossed pairs, reset zero
// - bit 13 reports pause receive resolution
// - bit 12 reports pause transmit resolution
// - pause bits only when full duplex
// - bit 11 injects one error, self clears
// - bit 9 pass flag, fail latched until the irq fail status bit is cleared
// - bit 7 bypasses LED stretching
`timescale 1ns/100ps
`include "plc_map.vh"
module plc_regs (
    input wire core_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire strap_auto_crossover,
    input wire strap_mode_bit0,
    input wire [4:0] strap_port_addr,
    input wire [1:0] local_advertise_pause,
    input wire [1:0] partner_ability_pause,
    input wire hcd_full_duplex,
    input wire selftest_error,
    input wire [2:0] raw_indicators,
    input wire [2:0] stretched_indicators,
    output wire speed_indicator_out,
    output wire link_indicator_out,
    output wire activity_collision_indicator_out,
    output wire auto_crossover_enable,
    output wire force_pair_crossover,
    output wire pause_rx_enable,
    output wire pause_tx_enable,
    output reg selftest_inject_error,
    output wire selftest_long_sequence_sel,
    output wire selftest_run,
    output wire indicator_stretch_bypass,
    output wire [1:0] indicator_mode_select,
    output wire [4:0] port_mgmt_address,
    output wire irq
);
    reg [5:0] led_ovr_q;
    reg [15:0] phy_ctl_q;
    reg strap_done_q;
    reg pass_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_mask_q;
    reg [2:0] irq_stat_d;
    reg pause_any_q;
    wire pause_rx_w;
    wire pause_tx_w;
    wire wr_w;
    wire rd_w;
    wire [15:0] phy_ctl_rd_w;
    wire [2:0] led_en_w;
    wire [2:0] led_val_w;
    wire [2:0] led_out_w;

    assign wr_w = psel && penable && pwrite;
    assign rd_w = psel && !pwrite;
    // zero-wait slave; unmapped addresses read zero and flag slverr
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == `PLC_ADDR_LED_OVR ||
        paddr == `PLC_ADDR_PHY_CTL || paddr == `PLC_ADDR_IRQ_STAT ||
        paddr == `PLC_ADDR_IRQ_MASK || paddr == `PLC_ADDR_LED_IN);

    plc_pause_resolve u_pause (
        .local_pause(local_advertise_pause),
        .partner_pause(partner_ability_pause),
        .full_duplex(hcd_full_duplex),
        .pause_rx(pause_rx_w),
        .pause_tx(pause_tx_w)
    );

    assign led_en_w = {led_ovr_q[`PLC_BIT_SPD_EN], led_ovr_q[`PLC_BIT_LNK_EN],
        led_ovr_q[`PLC_BIT_ACT_EN]};
    assign led_val_w = led_ovr_q[2:0];

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_led
            plc_led_mux u_mux (
                .raw_ind(raw_indicators[i]),
                .stretched_ind(stretched_indicators[i]),
                .bypass(phy_ctl_q[`PLC_BIT_BYPASS]),
                .override_en(led_en_w[i]),
                .forced_value(led_val_w[i]),
                .led_out(led_out_w[i])
            );
        end
    endgenerate

    // index 2 speed, 1 link, 0 activity/collision
    assign speed_indicator_out = led_out_w[2];
    assign link_indicator_out = led_out_w[1];
    assign activity_collision_indicator_out = led_out_w[0];

    assign auto_crossover_enable = phy_ctl_q[`PLC_BIT_XOVER_EN];
    assign force_pair_crossover = phy_ctl_q[`PLC_BIT_FORCE_X];
    assign pause_rx_enable = pause_rx_w;
    assign pause_tx_enable = pause_tx_w;
    assign selftest_long_sequence_sel = phy_ctl_q[`PLC_BIT_LONG_SEQ];
    assign selftest_run = phy_ctl_q[`PLC_BIT_RUN];
    assign indicator_stretch_bypass = phy_ctl_q[`PLC_BIT_BYPASS];
    // mode select is bits 6:5 as a two-bit value; bit 6 counts
    assign indicator_mode_select = phy_ctl_q[6:5];
    assign port_mgmt_address = phy_ctl_q[4:0];
    assign irq = |(irq_stat_q & irq_mask_q);

    assign phy_ctl_rd_w = {phy_ctl_q[15:14], pause_rx_w, pause_tx_w,
        1'b0, phy_ctl_q[10], pass_q, phy_ctl_q[8:0]};

    // straps are caught on the first clock after reset release, not in the reset branch
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            led_ovr_q <= 6'h00;
            phy_ctl_q <= 16'h0000;
            strap_done_q <= 1'b0;
            selftest_inject_error <= 1'b0;
        end else begin
            selftest_inject_error <= 1'b0;
            if (!strap_done_q) begin
                strap_done_q <= 1'b1;
                phy_ctl_q[`PLC_BIT_XOVER_EN] <= strap_auto_crossover;
                phy_ctl_q[5] <= strap_mode_bit0;
                phy_ctl_q[4:0] <= strap_port_addr;
            end else if (wr_w && paddr == `PLC_ADDR_LED_OVR) begin
                led_ovr_q <= pwdata[5:0];
            end else if (wr_w && paddr == `PLC_ADDR_PHY_CTL) begin
                phy_ctl_q <= pwdata[15:0] & `PLC_PHY_CTL_WMASK;
                // one-cycle pulse gives exactly one error; the bit never stores
                selftest_inject_error <= pwdata[`PLC_BIT_INJ_ERR];
            end
        end
    end

    // pass flag: zero while stopped; a fail holds it low until the irq fail status bit is cleared
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pass_q <= 1'b0;
        end else if (!phy_ctl_q[`PLC_BIT_RUN]) begin
            pass_q <= 1'b0;
        end else if (selftest_error) begin
            pass_q <= 1'b0;
        end else if (!pass_q && !(|irq_stat_q[`PLC_IRQ_FAIL]) && strap_done_q) begin
            pass_q <= 1'b1;
        end
    end

    // sticky events; a set in the clearing cycle wins
    always @* begin
        irq_stat_d = irq_stat_q;
        if (wr_w && paddr == `PLC_ADDR_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~pwdata[2:0];
        end
        if (phy_ctl_q[`PLC_BIT_RUN] && selftest_error) begin
            irq_stat_d[`PLC_IRQ_FAIL] = 1'b1;
        end
        if ((pause_rx_w | pause_tx_w) != pause_any_q) begin
            irq_stat_d[`PLC_IRQ_PAUSE] = 1'b1;
        end
        if (selftest_inject_error) begin
            irq_stat_d[`PLC_IRQ_INJ] = 1'b1;
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
            pause_any_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            pause_any_q <= pause_rx_w | pause_tx_w;
            if (wr_w && paddr == `PLC_ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata[2:0];
            end
        end
    end

    // read data registered in setup so it is stable in access
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (rd_w && !penable) begin
            case (paddr)
                `PLC_ADDR_LED_OVR: prdata <= {26'h0000000, led_ovr_q};
                `PLC_ADDR_PHY_CTL: prdata <= {16'h0000, phy_ctl_rd_w};
                `PLC_ADDR_IRQ_STAT: prdata <= {29'h00000000, irq_stat_q};
                `PLC_ADDR_IRQ_MASK: prdata <= {29'h00000000, irq_mask_q};
                `PLC_ADDR_LED_IN: prdata <= {29'h00000000, led_out_w};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule // plc_regs

// ---- verification/plc_regs_chk.sv ----
`timescale 1ns/100ps
module plc_regs_chk (
    input wire core_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire hcd_full_duplex,
    input wire [1:0] local_advertise_pause,
    input wire [1:0] partner_ability_pause,
    input wire pause_rx_enable,
    input wire pause_tx_enable,
    input wire selftest_inject_error,
    input wire selftest_run,
    input wire force_pair_crossover,
    input wire indicator_stretch_bypass,
    input wire link_indicator_out
);
    wire wr = psel && penable && pwrite;
    wire wc = wr && paddr == 12'h064;
    wire wl = wr && paddr == 12'h060;
    wire bsym = local_advertise_pause[0] && partner_ability_pause[0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_rsvd; psel && penable && !pwrite && paddr == 12'h060 |-> prdata[31:6] == 26'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    property p_ovr; wl && pwdata[4] |=> link_indicator_out == $past(pwdata[1]); endproperty
    a_ovr: assert property (p_ovr) else $error("link override not applied");
    property p_xover; wc |=> force_pair_crossover == $past(pwdata[14]); endproperty
    a_xover: assert property (p_xover) else $error("crossover not written");
    property p_hd; !hcd_full_duplex |-> !pause_rx_enable && !pause_tx_enable; endproperty
    a_hd: assert property (p_hd) else $error("pause in half duplex");
    property p_sym; hcd_full_duplex && bsym |-> pause_rx_enable && pause_tx_enable; endproperty
    a_sym: assert property (p_sym) else $error("symmetric pause missing");
    property p_inj; wc && pwdata[11] |=> selftest_inject_error ##1 !selftest_inject_error;
    endproperty
    a_inj: assert property (p_inj) else $error("inject not one pulse");
    property p_run; wc |=> selftest_run == $past(pwdata[8]); endproperty
    a_run: assert property (p_run) else $error("run not written");
    property p_byp; wc |=> indicator_stretch_bypass == $past(pwdata[7]); endproperty
    a_byp: assert property (p_byp) else $error("bypass not written");
    c_inj: cover property (selftest_inject_error);
    c_asym: cover property (pause_tx_enable && !pause_rx_enable);
    c_ovr: cover property (wl && pwdata[4]);
endmodule // plc_regs_chk
bind plc_regs plc_regs_chk chk_u (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .hcd_full_duplex(hcd_full_duplex), .local_advertise_pause(local_advertise_pause),
    .partner_ability_pause(partner_ability_pause), .pause_rx_enable(pause_rx_enable),
    .pause_tx_enable(pause_tx_enable), .selftest_inject_error(selftest_inject_error),
    .selftest_run(selftest_run), .force_pair_crossover(force_pair_crossover),
    .indicator_stretch_bypass(indicator_stretch_bypass), .link_indicator_out(link_indicator_out));

// ---- verification/plc_far_model.sv ----
`timescale 1ns/100ps
module plc_far_model (
    input wire core_clk,
    input wire reset,
    input wire inject,
    input wire run,
    output logic err,
    output logic [2:0] raw,
    output wire [2:0] str
);
    // the pattern checker sees a forced error one cycle after injection
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            raw <= 3'h0;
            err <= 1'h0;
        end else begin
            raw <= raw + 3'h1;
            err <= run & inject;
        end
    end
    // stretched copy differs from raw so a wrong mux choice shows
    assign str = ~raw;
endmodule // plc_far_model

// ---- verification/tb_phy_led_and_control_regs.sv ----
`timescale 1ns/100ps
module tb_phy_led_and_control_regs;
    logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, fd = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [1:0] lp = 0, pp = 0;
    wire pready, pslverr, ste, inj, run, lsel, byp, xen, fx, prx, ptx, irq;
    wire [31:0] prdata;
    wire [2:0] raw, str, led;
    wire [1:0] mode;
    wire [4:0] addr;
    int n_errors = 0, checked = 0;
    plc_regs dut_u (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .strap_auto_crossover(1'h1), .strap_mode_bit0(1'h1),
        .strap_port_addr(5'h15), .local_advertise_pause(lp), .partner_ability_pause(pp),
        .hcd_full_duplex(fd), .selftest_error(ste), .raw_indicators(raw),
        .stretched_indicators(str), .speed_indicator_out(led[2]), .link_indicator_out(led[1]),
        .activity_collision_indicator_out(led[0]), .auto_crossover_enable(xen),
        .force_pair_crossover(fx), .pause_rx_enable(prx), .pause_tx_enable(ptx),
        .selftest_inject_error(inj), .selftest_long_sequence_sel(lsel), .selftest_run(run),
        .indicator_stretch_bypass(byp), .indicator_mode_select(mode),
        .port_mgmt_address(addr), .irq(irq));
    plc_far_model far_u (.core_clk(core_clk), .reset(reset), .inject(inj), .run(run),
        .err(ste), .raw(raw), .str(str));
    initial forever #4 core_clk = ~core_clk;
    // wide enough for a flag joined to a full read word
    task chk(input logic [39:0] s, input logic [39:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("Error %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (k >= 20) begin
            n_errors++;
            wrap_up;
        end
    endtask
    function logic [2:0] lexp(input logic [5:0] v, input logic b);
        for (int j = 0; j < 3; j++)
            lexp[j] = v[3 + j] ? v[j] : (b ? raw[j] : str[j]);
    endfunction
    function logic [1:0] pz(input logic [1:0] l, input logic [1:0] p);
        pz[1] = l[0] & p[0] | l[1] & l[0] & ~p[0] & p[1];
        pz[0] = l[0] & p[0] | l[1] & ~l[0] & p[0] & p[1];
    endfunction
    task t_reset;
        apb(0, 12'h060, 0);
        chk(rd, 32'h0);
        apb(0, 12'h064, 0);
        chk(rd, 32'h8035);
        chk({mode, addr}, 7'h35);
        apb(0, 12'h0F0, 0);
        chk({err, rd}, 33'h100000000);
    endtask
    task t_led;
        logic [5:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 6'h0B * i;
            // bit 7 bypass follows i[0]; crossover and the other bits are written clear
            apb(1, 12'h064, {24'h0, i[0], 7'h0});
            apb(1, 12'h060, {26'h3FFFFFF, v});
            apb(0, 12'h060, 0);
            chk(rd, v);
            @(negedge core_clk);
            chk(led, lexp(v, i[0]));
        end
    endtask
    task t_pause;
        for (int i = 0; i < 32; i++) begin
            @(posedge core_clk);
            {fd, lp, pp} <= i[4:0];
            @(negedge core_clk);
            chk({prx, ptx}, fd ? pz(lp, pp) : 2'h0);
        end
        apb(0, 12'h064, 0);
        chk(rd[13:12], 2'h3);
    endtask
    task t_bist;
        apb(1, 12'h064, 32'hC500);
        apb(0, 12'h064, 0);
        chk({xen, fx, lsel, run, rd[15:8]}, 12'hFF7);
        apb(1, 12'h064, 32'h0D00);
        // injected error reaches the pass flag two edges after the write
        repeat (2) @(posedge core_clk);
        apb(0, 12'h064, 0);
        chk({fx, rd[11:8]}, 5'h05);
        apb(1, 12'h084, 32'h5);
        apb(0, 12'h080, 0);
        chk({irq, rd[2] , rd[0]}, 3'h7);
        apb(1, 12'h064, 32'h0);
        apb(1, 12'h080, 32'h7);
        apb(0, 12'h080, 0);
        chk({irq, rd}, 33'h0);
        apb(1, 12'h064, 32'h0100);
        apb(0, 12'h064, 0);
        chk(rd[9], 1'h1);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'h0;
        t_reset;
        t_led;
        t_pause;
        t_bist;
        wrap_up;
    end
endmodule // tb_phy_led_and_control_regs
